// *** stlc_core.sv ***
// serial interface transfer sequencing with its register file
module stlc_core
	import stlc_pkg::*;
(
	input  wire logic        mclk,      // module clock, 25 MHz
	input  wire logic        arst_n,    // async reset, active low
	input  wire logic        reg_wr,    // register write strobe
	input  wire logic        reg_rd,    // register read strobe
	input  wire logic [4:0]  reg_addr,  // register byte offset
	input  wire logic [31:0] reg_wdata, // register write data
	output logic      [31:0] reg_rdata, // read data, one cycle after reg_rd
	output logic             done,      // transfer-done flag level
	input  wire logic        sck_i,     // serial clock pin in
	output logic             sck_o,     // serial clock pin out
	output logic             sck_oe,    // serial clock drive enable
	input  wire logic        mosi_i,    // master-out pin in
	output logic             mosi_o,    // master-out pin out
	output logic             mosi_oe,   // master-out drive enable
	input  wire logic        miso_i,    // master-in pin in
	output logic             miso_o,    // master-in pin out
	output logic             miso_oe,   // master-in drive enable
	input  wire logic        ss_n_i,    // slave select in, active low
	output logic             ss_n_o,    // slave select out, active low
	output logic             ss_oe      // slave select drive enable
);
	typedef struct packed {
		stlc_state_t state;
		logic [31:0] shift;
		logic [31:0] rx;
		logic [31:0] setup;
		logic [31:0] rdata;
		logic [7:0]  cnt;
		logic [6:0]  len;
		logic [6:0]  slv_cnt;
		logic        done;
		logic        sck_prev;
		logic        sck_o;
		logic        mosi_o;
		logic        mosi_oe;
		logic        miso_o;
		logic        miso_oe;
		logic        ss_n_o;
		logic        master;
	} stlc_core_t;

	stlc_core_t s_r;
	stlc_core_t s_nxt;

	logic       gen_rise;
	logic       gen_fall;
	logic       gen_level;
	logic       slave_role;
	logic       shared;
	logic       pol;
	logic [1:0] idle_sel;
	logic       din;
	logic       wr_cc;
	logic       start_req;
	logic       slv_edge;
	logic       run_fall;

	assign slave_role = s_r.setup[STLC_SU_ROLE_BIT];
	assign shared = s_r.setup[STLC_SU_SHARED_BIT];
	assign pol = s_r.setup[STLC_SU_POL_BIT];
	assign idle_sel = s_r.setup[STLC_SU_IDLE_LSB +: 2];
	// shared line: master listens on mosi, slave on miso
	assign din = (shared ^ slave_role) ? mosi_i : miso_i;
	assign wr_cc = reg_wr && (reg_addr == STLC_OFF_CLK_CTRL);
	assign start_req = wr_cc && reg_wdata[STLC_CC_START_BIT];
	assign slv_edge = ((sck_i ^ pol) && !s_r.sck_prev);
	assign run_fall = (s_r.state == STLC_ST_RUN) && gen_fall;

	stlc_sck_gen u_gen (
		.mclk    (mclk),
		.arst_n  (arst_n),
		.run     (s_r.state == STLC_ST_RUN),
		.div_sel (s_r.setup[STLC_SU_DIV_LSB +: 3]),
		.rise    (gen_rise),
		.fall    (gen_fall),
		.level   (gen_level)
	);

	always_comb begin
		s_nxt = s_r;
		s_nxt.sck_prev = sck_i ^ pol;
		s_nxt.master = ~slave_role;
		// register writes
		if (wr_cc) begin
			s_nxt.cnt = reg_wdata[STLC_CC_CNT_LSB +: 8];
			s_nxt.len = reg_wdata[STLC_CC_LEN_LSB +: 7];
		end
		if (reg_wr && reg_addr == STLC_OFF_SETUP) begin
			s_nxt.setup = reg_wdata & STLC_SU_MASK;
		end
		if (reg_wr && reg_addr == STLC_OFF_TX) begin
			s_nxt.shift = reg_wdata;
		end
		if (reg_wr && reg_addr == STLC_OFF_STATUS
				&& reg_wdata[STLC_ST_DONE_BIT]) begin
			s_nxt.done = 1'b0;
		end
		case (s_r.state)
			STLC_ST_IDLE: begin
				// go only acts in master role and when idle
				if (start_req && !slave_role) begin
					s_nxt.state = STLC_ST_RUN;
					s_nxt.done = 1'b0;
				end
			end
			STLC_ST_RUN: begin
				if (gen_fall) begin
					if (s_r.len != 7'h00) begin
						// one register for both ways: after 32 shifts the
						// received bits reach the output end
						s_nxt.shift = {s_r.shift[30:0], din};
						s_nxt.len = s_r.len - 7'h01;
					end
					if (s_r.cnt == 8'h00) begin
						s_nxt.state = STLC_ST_IDLE;
						s_nxt.rx = s_nxt.shift;
						s_nxt.done = 1'b1;
					end else begin
						s_nxt.cnt = s_r.cnt - 8'h01;
					end
				end
			end
			default: s_nxt.state = STLC_ST_IDLE;
		endcase
		// slave reception; the period count is not used here
		if (!slave_role || ss_n_i) begin
			s_nxt.slv_cnt = 7'h00;
		end else if (slv_edge) begin
			s_nxt.shift = {s_r.shift[30:0], din};
			if (s_r.slv_cnt == s_r.len) begin
				s_nxt.slv_cnt = 7'h00;
				s_nxt.rx = s_nxt.shift;
				s_nxt.done = 1'b1;
			end else begin
				s_nxt.slv_cnt = s_r.slv_cnt + 7'h01;
			end
		end
		// pin drive
		s_nxt.sck_o = pol ^ ((s_r.state == STLC_ST_RUN) && gen_level);
		s_nxt.ss_n_o = ~(s_r.state == STLC_ST_RUN);
		s_nxt.miso_o = s_nxt.shift[31];
		s_nxt.miso_oe = slave_role && !ss_n_i;
		if (s_r.state == STLC_ST_RUN && s_nxt.len != 7'h00) begin
			s_nxt.mosi_o = s_nxt.shift[31];
			s_nxt.mosi_oe = 1'b1;
		end else begin
			// output exhausted: apply the selected idle behaviour, but release the line when shared or in slave role
			s_nxt.mosi_oe = 1'b1;
			case (idle_sel)
				STLC_IDLE_LOW: s_nxt.mosi_o = 1'b0;
				STLC_IDLE_HIGH: s_nxt.mosi_o = 1'b1;
				STLC_IDLE_HOLD: s_nxt.mosi_o = s_r.mosi_o;
				default: s_nxt.mosi_oe = 1'b0;
			endcase
			if (shared || slave_role) begin
				s_nxt.mosi_oe = 1'b0;
			end
		end
		// read data
		if (reg_rd) begin
			case (reg_addr)
				STLC_OFF_TX: s_nxt.rdata = s_r.shift;
				STLC_OFF_RX: s_nxt.rdata = s_r.rx;
				// go bit position always reads zero
				STLC_OFF_CLK_CTRL: s_nxt.rdata = {16'h0000, s_r.cnt, 1'b0,
					s_r.len};
				STLC_OFF_SETUP: s_nxt.rdata = s_r.setup;
				STLC_OFF_STATUS: s_nxt.rdata = {31'h0, s_r.done};
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
			s_r.state <= STLC_ST_IDLE;
			s_r.setup <= STLC_SETUP_RST;
			s_r.cnt <= STLC_CNT_RST;
			s_r.len <= STLC_LEN_RST;
			s_r.shift <= STLC_DATA_RST;
			s_r.rx <= STLC_DATA_RST;
			s_r.ss_n_o <= 1'b1;
			s_r.master <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata = s_r.rdata;
	assign done = s_r.done;
	assign sck_o = s_r.sck_o;
	assign sck_oe = s_r.master;
	assign mosi_o = s_r.mosi_o;
	assign mosi_oe = s_r.mosi_oe;
	assign miso_o = s_r.miso_o;
	assign miso_oe = s_r.miso_oe;
	assign ss_n_o = s_r.ss_n_o;
	assign ss_oe = s_r.master;

	property p_start_run;
		@(posedge mclk) disable iff (!arst_n)
		(start_req && !slave_role && s_r.state == STLC_ST_IDLE)
			|=> (s_r.state == STLC_ST_RUN && !s_r.done);
	endproperty
	a_start_run: assert property (p_start_run)
		else $error("go write did not start transfer");

	property p_slave_go;
		@(posedge mclk) disable iff (!arst_n)
		(start_req && slave_role && s_r.state == STLC_ST_IDLE)
			|=> (s_r.state == STLC_ST_IDLE);
	endproperty
	a_slave_go: assert property (p_slave_go)
		else $error("go write acted in slave role");

	property p_cnt_dec;
		@(posedge mclk) disable iff (!arst_n)
		(run_fall && s_r.cnt != 8'h00 && !wr_cc)
			|=> (s_r.cnt == $past(s_r.cnt) - 8'h01);
	endproperty
	a_cnt_dec: assert property (p_cnt_dec)
		else $error("period count did not decrement");

	property p_end;
		@(posedge mclk) disable iff (!arst_n)
		(run_fall && s_r.cnt == 8'h00)
			|=> (s_r.state == STLC_ST_IDLE && s_r.done
				&& s_r.rx == s_r.shift);
	endproperty
	a_end: assert property (p_end)
		else $error("transfer did not end after last period");

	property p_len_dec;
		@(posedge mclk) disable iff (!arst_n)
		(run_fall && s_r.len != 7'h00 && !wr_cc)
			|=> (s_r.len == $past(s_r.len) - 7'h01)
				##1 (s_r.mosi_o == $past(s_r.shift[31], 1) || !s_r.mosi_oe
				|| s_r.len == 7'h00 || s_r.state != STLC_ST_RUN);
	endproperty
	a_len_dec: assert property (p_len_dec)
		else $error("shift length did not decrement");

	property p_mosi_idle;
		@(posedge mclk) disable iff (!arst_n)
		(s_r.state == STLC_ST_RUN && s_r.len == 7'h00 && !wr_cc
			&& !shared && idle_sel == STLC_IDLE_LOW && !slave_role)
			|=> (s_r.mosi_o == 1'b0 && s_r.mosi_oe);
	endproperty
	a_mosi_idle: assert property (p_mosi_idle)
		else $error("output not idle after length reached zero");

	property p_slv_cap;
		@(posedge mclk) disable iff (!arst_n)
		(slave_role && !ss_n_i && slv_edge && s_r.slv_cnt == s_r.len)
			|=> (s_r.done && s_r.slv_cnt == 7'h00 && s_r.rx == s_r.shift);
	endproperty
	a_slv_cap: assert property (p_slv_cap)
		else $error("slave match did not capture word");

	property p_slv_clr;
		@(posedge mclk) disable iff (!arst_n)
		(slave_role && ss_n_i) |=> (s_r.slv_cnt == 7'h00);
	endproperty
	a_slv_clr: assert property (p_slv_clr)
		else $error("slave counter not cleared on deselect");

	property p_go_reads_zero;
		@(posedge mclk) disable iff (!arst_n)
		(reg_rd && reg_addr == STLC_OFF_CLK_CTRL)
			|=> (reg_rdata[STLC_CC_START_BIT] == 1'b0);
	endproperty
	a_go_reads_zero: assert property (p_go_reads_zero)
		else $error("go bit read back as one");
endmodule

// *** stlc_pkg.sv ***
// constants and types shared by the transfer length control block
package stlc_pkg;
	// register offsets
	localparam logic [4:0]  STLC_OFF_TX        = 5'h00;
	localparam logic [4:0]  STLC_OFF_RX        = 5'h04;
	localparam logic [4:0]  STLC_OFF_CLK_CTRL  = 5'h08;
	localparam logic [4:0]  STLC_OFF_SETUP     = 5'h0c;
	localparam logic [4:0]  STLC_OFF_STATUS    = 5'h10;
	// transfer_clock_control fields
	localparam int          STLC_CC_LEN_LSB    = 0;
	localparam int          STLC_CC_START_BIT  = 7;
	localparam int          STLC_CC_CNT_LSB    = 8;
	// transfer_setup fields
	localparam int          STLC_SU_SHARED_BIT = 17;
	localparam int          STLC_SU_ROLE_BIT   = 16;
	localparam int          STLC_SU_DIV_LSB    = 12;
	localparam int          STLC_SU_POL_BIT    = 8;
	localparam int          STLC_SU_IDLE_LSB   = 4;
	localparam logic [31:0] STLC_SU_MASK       = 32'h0003_773f;
	// status fields
	localparam int          STLC_ST_DONE_BIT   = 0;
	// reset values
	localparam logic [31:0] STLC_SETUP_RST     = 32'h0000_0000;
	localparam logic [7:0]  STLC_CNT_RST       = 8'h00;
	localparam logic [6:0]  STLC_LEN_RST       = 7'h00;
	localparam logic [31:0] STLC_DATA_RST      = 32'h0000_0000;
	// divider counter reset and step
	localparam logic [6:0]  STLC_DIV_RST       = 7'h00;
	localparam logic [6:0]  STLC_DIV_ONE       = 7'h01;

	typedef enum logic [1:0] {
		STLC_ST_IDLE = 2'b01,
		STLC_ST_RUN  = 2'b10
	} stlc_state_t;

	typedef enum logic [1:0] {
		STLC_IDLE_LOW     = 2'h0,
		STLC_IDLE_HIGH    = 2'h1,
		STLC_IDLE_HOLD    = 2'h2,
		STLC_IDLE_RELEASE = 2'h3
	} stlc_idle_t;
endpackage

// *** stlc_sck_gen.sv ***
// serial clock divider for master transfers
module stlc_sck_gen
	import stlc_pkg::*;
(
	input  wire logic       mclk,    // module clock
	input  wire logic       arst_n,  // async reset, active low
	input  wire logic       run,     // divider runs while high
	input  wire logic [2:0] div_sel, // clock_divider_select field
	output logic            rise,    // pulse on serial clock first edge
	output logic            fall,    // pulse on serial clock second edge
	output logic            level    // internal serial clock level
);
	typedef struct packed {
		logic [6:0] cnt;
		logic       lvl;
		logic       rise;
		logic       fall;
	} stlc_gen_t;

	stlc_gen_t s_r;
	stlc_gen_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.rise = 1'b0;
		s_nxt.fall = 1'b0;
		if (!run) begin
			s_nxt.cnt = STLC_DIV_RST;
			s_nxt.lvl = 1'b0;
		// half period is 2^div_sel cycles, so a period is 2^(div_sel+1)
		end else if (s_r.cnt == (STLC_DIV_ONE << div_sel) - STLC_DIV_ONE) begin
			s_nxt.cnt = STLC_DIV_RST;
			s_nxt.lvl = ~s_r.lvl;
			s_nxt.rise = ~s_r.lvl;
			s_nxt.fall = s_r.lvl;
		end else begin
			s_nxt.cnt = s_r.cnt + STLC_DIV_ONE;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rise = s_r.rise;
	assign fall = s_r.fall;
	assign level = s_r.lvl;
endmodule

// *** stlc_spi_peer.sv ***
// external serial peer: answers a master with a fixed byte
module stlc_spi_peer (
	input  wire logic       sck,  // serial clock from the master
	input  wire logic       ss_n, // select, active low
	input  wire logic       mosi, // data from the master
	output logic            miso, // data to the master
	output logic [7:0]      got   // bits seen on mosi, last in lsb
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh;
	initial begin
		sh = 8'h3c;
		miso = 1'b0;
		got = 8'h00;
	end
	always @(negedge ss_n) begin
		sh = 8'h3c;
		miso = sh[7];
	end
	// released line shows the inverse so a stale bit cannot pass
	always @(posedge ss_n) miso = ~miso;
	always @(posedge sck) if (!ss_n) got = {got[6:0], mosi};
	// next bit goes out after the trailing edge
	always @(negedge sck) if (!ss_n) begin
		sh = {sh[6:0], 1'b0};
		miso = sh[7];
	end
endmodule

// *** spi_transfer_length_control_tb.sv ***
// self-checking bench for the transfer length control block
module spi_transfer_length_control_tb import stlc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, arst_n, reg_wr, reg_rd, done;
	logic [4:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d, nrise, bad_count, num_checks;
	logic        sck_i, sck_o, sck_oe, mosi_i, mosi_o, mosi_oe;
	logic        miso_i, miso_o, miso_oe, ss_n_i, ss_n_o, ss_oe;
	logic [7:0]  got;
	time         t_last, per;

	stlc_core dut (.mclk(mclk), .arst_n(arst_n), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .done(done), .sck_i(sck_i), .sck_o(sck_o),
		.sck_oe(sck_oe), .mosi_i(mosi_i), .mosi_o(mosi_o),
		.mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o),
		.miso_oe(miso_oe), .ss_n_i(ss_n_i), .ss_n_o(ss_n_o), .ss_oe(ss_oe));
	stlc_spi_peer peer (.sck(sck_o), .ss_n(ss_n_o), .mosi(mosi_o),
		.miso(miso_i), .got(got));

	always #20 mclk = ~mclk;
	always @(posedge sck_o) begin
		per = $time - t_last;
		t_last = $time;
		nrise++;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] v);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic wait_done();
		// let a clear made by the start write settle before looking
		@(posedge mclk);
		for (int i = 0; i < 2000 && done !== 1'b1; i++) @(posedge mclk);
		#1 chk({31'h0, done}, 32'h1);
	endtask
	// master side driven by the bench for slave role, msb first
	task automatic frame(input logic [7:0] v, input int n);
		@(posedge mclk);
		ss_n_i <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			repeat (4) @(posedge mclk);
			mosi_i <= v[i];
			repeat (4) @(posedge mclk);
			sck_i <= 1'b1;
			repeat (4) @(posedge mclk);
			sck_i <= 1'b0;
		end
		repeat (4) @(posedge mclk);
		ss_n_i <= 1'b1;
		mosi_i <= ~mosi_i;
	endtask
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#400000;
		bad_count++;
		conclude();
	end

	initial begin
		{mclk, arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{sck_i, mosi_i, ss_n_i} = 3'b001;
		{bad_count, num_checks, nrise, t_last, per} = '0;
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		rd(STLC_OFF_SETUP, d); chk(d, 32'h0);
		rd(STLC_OFF_CLK_CTRL, d); chk(d, 32'h0);
		rd(5'h14, d); chk(d, 32'h0);
		wr(STLC_OFF_TX, 32'ha500_0000);
		nrise = '0;
		wr(STLC_OFF_CLK_CTRL, 32'h0000_0788);
		wait_done();
		chk(nrise, 32'h8);
		chk(per[31:0], 32'h50);
		chk({24'h0, got}, 32'ha5);
		chk({30'h0, mosi_oe, mosi_o}, 32'h2);
		chk({30'h0, ss_oe, sck_oe}, 32'h3);
		rd(STLC_OFF_RX, d); chk(d, 32'h3c);
		rd(STLC_OFF_CLK_CTRL, d); chk(d & 32'hff, 32'h0);
		wr(STLC_OFF_SETUP, 32'h0000_2000);
		wr(STLC_OFF_TX, 32'hc000_0001);
		nrise = '0;
		wr(STLC_OFF_CLK_CTRL, 32'h0000_0384);
		repeat (2) @(posedge mclk);
		#1 chk({31'h0, done}, 32'h0);
		wait_done();
		chk(nrise, 32'h4);
		chk(per[31:0], 32'h140);
		chk({28'h0, got[3:0]}, 32'hc);
		rd(STLC_OFF_RX, d); chk(d, 32'h13);
		// more periods than shifts: output idles for the tail
		wr(STLC_OFF_TX, 32'hffff_ffff);
		nrise = '0;
		wr(STLC_OFF_CLK_CTRL, 32'h0000_0382);
		wait_done();
		chk(nrise, 32'h4);
		chk({28'h0, got[3:0]}, 32'hc);
		chk({30'h0, mosi_oe, mosi_o}, 32'h2);
		rd(STLC_OFF_RX, d); chk(d, 32'hffff_fffc);
		wr(STLC_OFF_SETUP, 32'h0000_2010);
		wr(STLC_OFF_TX, 32'h0);
		wr(STLC_OFF_CLK_CTRL, 32'h0000_0382);
		wait_done();
		chk({28'h0, got[3:0]}, 32'h3);
		chk({30'h0, mosi_oe, mosi_o}, 32'h3);
		wr(STLC_OFF_SETUP, 32'h0000_2020);
		wr(STLC_OFF_TX, 32'h4000_0000);
		wr(STLC_OFF_CLK_CTRL, 32'h0000_0382);
		wait_done();
		chk({28'h0, got[3:0]}, 32'h7);
		chk({30'h0, mosi_oe, mosi_o}, 32'h3);
		wr(STLC_OFF_STATUS, 32'h1);
		#1 chk({31'h0, done}, 32'h0);
		wr(STLC_OFF_SETUP, 32'h0001_0000);
		wr(STLC_OFF_TX, 32'h8000_0000);
		wr(STLC_OFF_CLK_CTRL, 32'h0000_0087);
		repeat (4) @(posedge mclk);
		#1 chk({29'h0, ss_oe, sck_oe, done}, 32'h0);
		@(posedge mclk);
		ss_n_i <= 1'b0;
		repeat (2) @(posedge mclk);
		#1 chk({30'h0, miso_oe, miso_o}, 32'h3);
		frame(8'h05, 3);
		repeat (3) @(posedge mclk);
		#1 chk({31'h0, done}, 32'h0);
		chk({31'h0, miso_oe}, 32'h0);
		frame(8'h96, 8);
		repeat (3) @(posedge mclk);
		#1 chk({31'h0, done}, 32'h1);
		rd(STLC_OFF_RX, d); chk(d, 32'h596);
		conclude();
	end
endmodule
